/* File: src/txe_top.sv */
// table write, test-skip and xor execution block behind an apb slave
//
// Summary of operation
// - table write low opcode bits pick keep, post-inc, post-dec or pre-inc of the pointer; one word, two cycles.
// - table write copies the latch byte into the holding register picked by pointer bits 2..0, flags untouched.
// - the table pointer is 21 bits wide and steps across its full width.
// - pointer bit 0 tells low byte (0) from high byte (1) of the word.
// - test-skip reads the file register and, if it is zero, turns the next instruction into a nop, flags untouched.
// - test-skip takes one cycle without skip, two skipping one word, three skipping two words.
// - access bit 0 picks the access bank, 1 uses the bank select register.
// - with access bit 0 and the extended set on, addresses up to 95 are offsets from the index base.
// - xor literal puts w xor literal into w in one cycle, setting negative and zero.
// - xor file puts w xor file into w (d=0) or the file (d=1) in one cycle, setting negative and zero.
// - the extended set is off after reset and only a set control bit turns it on.
`timescale 1ns/10ps
`include "txe_consts.svh"

module txe_top #(
    parameter int FILE_ADDR_W = 9,
    parameter int HOLD_COUNT = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TXE_PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // to the flash programming side
    output logic hold_we,
    output logic [$clog2(HOLD_COUNT)-1:0] hold_index,
    output logic [7:0] hold_data,
    output logic hold_byte_high,
    output logic [20:0] table_pointer
);

    localparam int HW = $clog2(HOLD_COUNT);

    txe_pkg::txe_state_t state;
    txe_pkg::txe_op_t op;
    logic [1:0] q_cnt;
    logic cyc_en;
    logic [15:0] instr_reg;
    logic [1:0] elapsed;
    logic [1:0] total;
    logic ext_en;
    logic next_two_word;
    logic [7:0] w_reg;
    logic [7:0] table_latch;
    logic [3:0] bank_select_register;
    logic [11:0] index_base;
    logic [FILE_ADDR_W-1:0] file_index;
    logic [7:0] file_mem [2**FILE_ADDR_W];
    logic flag_z;
    logic flag_n;
    logic last_skip;
    logic last_illegal;
    logic [1:0] last_cycles;
    logic [1:0] ptr_mode;
    logic dest_file;
    logic [7:0] literal;
    logic [11:0] eff_addr;
    logic [7:0] file_val;
    logic [7:0] xor_res;
    logic busy;
    logic finish;
    logic access;
    logic wr_ok;
    logic [20:0] ptr_inc;
    logic [20:0] ptr_dec;
    logic [20:0] write_ptr;
    logic [HW-1:0] hold_rd_index;
    logic [7:0] hold_rd_data;
    logic [31:0] next_prdata;

    function automatic logic reg_mapped(input logic [`TXE_PADDR_W-1:0] a);
        reg_mapped = (a[1:0] == 2'h0) &&
                     ((a <= `TXE_OFF_FILE_DATA) ||
                      ((a >= `TXE_OFF_HOLD_FIRST) &&
                       (a <= `TXE_OFF_HOLD_LAST)));
    endfunction

    function automatic logic hit(input logic [`TXE_PADDR_W-1:0] a,
                                 input logic [`TXE_PADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // instruction cycle enable, four clocks per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_cnt <= 2'h0;
        end else if (q_cnt == `TXE_Q_LAST) begin
            q_cnt <= 2'h0;
        end else begin
            q_cnt <= q_cnt + 2'h1;
        end
    end
    assign cyc_en = (q_cnt == `TXE_Q_LAST);

    txe_decode u_decode (
        .instr(instr_reg),
        .ext_en(ext_en),
        .bank_select_register(bank_select_register),
        .index_base(index_base),
        .op(op),
        .ptr_mode(ptr_mode),
        .dest_file(dest_file),
        .literal(literal),
        .eff_addr(eff_addr)
    );

    // apb: zero wait states; writes other than control refused while busy
    assign busy = (state == txe_pkg::TXE_RUN);
    assign access = psel & penable;
    assign pready = 1'b1;
    assign pslverr = access & (~reg_mapped(paddr) |
                     (pwrite & busy & ~hit(paddr, `TXE_OFF_CTRL)));
    assign wr_ok = access & pwrite & ~pslverr;

    assign file_val = file_mem[eff_addr[FILE_ADDR_W-1:0]];
    assign xor_res = w_reg ^
                     ((op == txe_pkg::TXE_OP_XOR_LITERAL) ? literal : file_val);

    // length of the running instruction in instruction cycles
    always_comb begin
        case (op)
            txe_pkg::TXE_OP_TABLE_WRITE: total = `TXE_CYC_TWO;
            txe_pkg::TXE_OP_TEST_SKIP: begin
                if (file_val != 8'h00) begin
                    total = `TXE_CYC_ONE;
                end else if (next_two_word) begin
                    total = `TXE_CYC_THREE;
                end else begin
                    total = `TXE_CYC_TWO;
                end
            end
            default: total = `TXE_CYC_ONE;
        endcase
    end

    // effects land at the last cycle edge; only the control bits can move meanwhile
    assign finish = busy & cyc_en & ((elapsed + 2'h1) == total);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= txe_pkg::TXE_IDLE;
            elapsed <= 2'h0;
            instr_reg <= 16'h0000;
        end else begin
            case (state)
                txe_pkg::TXE_IDLE: begin
                    if (wr_ok && hit(paddr, `TXE_OFF_INSTR)) begin
                        instr_reg <= pwdata[15:0];
                        elapsed <= 2'h0;
                        state <= txe_pkg::TXE_RUN;
                    end
                end
                txe_pkg::TXE_RUN: begin
                    if (finish) begin
                        state <= txe_pkg::TXE_IDLE;
                    end else if (cyc_en) begin
                        elapsed <= elapsed + 2'h1;
                    end
                end
                default: state <= txe_pkg::TXE_IDLE;
            endcase
        end
    end

    // control: extended set off out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_en <= 1'b0;
            next_two_word <= 1'b0;
        end else if (wr_ok && hit(paddr, `TXE_OFF_CTRL)) begin
            ext_en <= pwdata[`TXE_CTRL_EXT_BIT];
            next_two_word <= pwdata[`TXE_CTRL_TWO_WORD_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_reg <= 8'h00;
        end else if (finish && ((op == txe_pkg::TXE_OP_XOR_LITERAL) ||
                     ((op == txe_pkg::TXE_OP_XOR_FILE) && !dest_file))) begin
            w_reg <= xor_res;
        end else if (wr_ok && hit(paddr, `TXE_OFF_WREG)) begin
            w_reg <= pwdata[7:0];
        end
    end

    // flags: only the xor forms touch them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_z <= 1'b0;
            flag_n <= 1'b0;
        end else if (finish && ((op == txe_pkg::TXE_OP_XOR_LITERAL) ||
                                (op == txe_pkg::TXE_OP_XOR_FILE))) begin
            flag_z <= (xor_res == 8'h00);
            flag_n <= xor_res[7];
        end
    end

    // file memory: no reset, contents undefined until written
    always_ff @(posedge pclk) begin
        if (finish && (op == txe_pkg::TXE_OP_XOR_FILE) && dest_file) begin
            file_mem[eff_addr[FILE_ADDR_W-1:0]] <= xor_res;
        end else if (wr_ok && hit(paddr, `TXE_OFF_FILE_DATA)) begin
            file_mem[file_index] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_latch <= 8'h00;
            bank_select_register <= 4'h0;
            index_base <= 12'h000;
            file_index <= '0;
        end else if (wr_ok) begin
            if (hit(paddr, `TXE_OFF_LATCH)) begin
                table_latch <= pwdata[7:0];
            end
            if (hit(paddr, `TXE_OFF_BANK)) begin
                bank_select_register <= pwdata[3:0];
            end
            if (hit(paddr, `TXE_OFF_INDEX_BASE)) begin
                index_base <= pwdata[11:0];
            end
            if (hit(paddr, `TXE_OFF_FILE_INDEX)) begin
                file_index <= pwdata[FILE_ADDR_W-1:0];
            end
        end
    end

    // table pointer: full-width wrap in both directions
    assign ptr_inc = table_pointer + 21'h00_0001;
    assign ptr_dec = table_pointer - 21'h00_0001;
    assign write_ptr = (ptr_mode == `TXE_PTR_PRE_INC) ? ptr_inc :
                       table_pointer;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_pointer <= 21'h00_0000;
        end else if (finish && (op == txe_pkg::TXE_OP_TABLE_WRITE)) begin
            case (ptr_mode)
                `TXE_PTR_POST_INC: table_pointer <= ptr_inc;
                `TXE_PTR_POST_DEC: table_pointer <= ptr_dec;
                `TXE_PTR_PRE_INC: table_pointer <= ptr_inc;
                default: table_pointer <= table_pointer;
            endcase
        end else if (wr_ok && hit(paddr, `TXE_OFF_TABLE_PTR)) begin
            table_pointer <= pwdata[20:0];
        end
    end

    // outcome of the last instruction, for software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_skip <= 1'b0;
            last_illegal <= 1'b0;
            last_cycles <= 2'h0;
        end else if (finish) begin
            last_skip <= (op == txe_pkg::TXE_OP_TEST_SKIP) &&
                         (file_val == 8'h00);
            last_illegal <= (op == txe_pkg::TXE_OP_NONE);
            last_cycles <= total;
        end
    end

    txe_holding #(
        .HOLD_COUNT(HOLD_COUNT)
    ) u_holding (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(finish && (op == txe_pkg::TXE_OP_TABLE_WRITE)),
        .wr_index(write_ptr[HW-1:0]),
        .wr_data(table_latch),
        .wr_byte_high(write_ptr[0]),
        .rd_index(hold_rd_index),
        .rd_data(hold_rd_data),
        .hold_we(hold_we),
        .hold_index(hold_index),
        .hold_data(hold_data),
        .hold_byte_high(hold_byte_high)
    );

    assign hold_rd_index = HW'((paddr - `TXE_OFF_HOLD_FIRST) >> 2);

    // read data captured in the setup phase, held for the access phase
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (reg_mapped(paddr)) begin
            case (paddr)
                `TXE_OFF_CTRL: begin
                    next_prdata[`TXE_CTRL_EXT_BIT] = ext_en;
                    next_prdata[`TXE_CTRL_TWO_WORD_BIT] = next_two_word;
                end
                `TXE_OFF_INSTR: next_prdata[15:0] = instr_reg;
                `TXE_OFF_STATUS: begin
                    next_prdata[`TXE_ST_BUSY_BIT] = busy;
                    next_prdata[`TXE_ST_SKIP_BIT] = last_skip;
                    next_prdata[`TXE_ST_ZERO_BIT] = flag_z;
                    next_prdata[`TXE_ST_NEG_BIT] = flag_n;
                    next_prdata[`TXE_ST_ILLEGAL_BIT] = last_illegal;
                    next_prdata[`TXE_ST_CYC_MSB:`TXE_ST_CYC_LSB] = last_cycles;
                end
                `TXE_OFF_WREG: next_prdata[7:0] = w_reg;
                `TXE_OFF_LATCH: next_prdata[7:0] = table_latch;
                `TXE_OFF_TABLE_PTR: next_prdata[20:0] = table_pointer;
                `TXE_OFF_BANK: next_prdata[3:0] = bank_select_register;
                `TXE_OFF_INDEX_BASE: next_prdata[11:0] = index_base;
                `TXE_OFF_FILE_INDEX: next_prdata[FILE_ADDR_W-1:0] = file_index;
                `TXE_OFF_FILE_DATA: next_prdata[7:0] = file_mem[file_index];
                default: next_prdata[7:0] = hold_rd_data;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= next_prdata;
        end
    end

endmodule // txe_top

/* File: src/txe_consts.svh */
// constants for the table write, test-skip and xor execution block
`ifndef TXE_CONSTS_SVH
`define TXE_CONSTS_SVH

// apb register byte offsets
`define TXE_PADDR_W 8
`define TXE_OFF_CTRL 8'h00
`define TXE_OFF_INSTR 8'h04
`define TXE_OFF_STATUS 8'h08
`define TXE_OFF_WREG 8'h0C
`define TXE_OFF_LATCH 8'h10
`define TXE_OFF_TABLE_PTR 8'h14
`define TXE_OFF_BANK 8'h18
`define TXE_OFF_INDEX_BASE 8'h1C
`define TXE_OFF_FILE_INDEX 8'h20
`define TXE_OFF_FILE_DATA 8'h24
`define TXE_OFF_HOLD_FIRST 8'h40
`define TXE_OFF_HOLD_LAST 8'h5C

// control and status fields
`define TXE_CTRL_EXT_BIT 0
`define TXE_CTRL_TWO_WORD_BIT 1
`define TXE_ST_BUSY_BIT 0
`define TXE_ST_SKIP_BIT 1
`define TXE_ST_ZERO_BIT 2
`define TXE_ST_NEG_BIT 3
`define TXE_ST_ILLEGAL_BIT 4
`define TXE_ST_CYC_LSB 8
`define TXE_ST_CYC_MSB 9

// opcode masks and match values
`define TXE_MASK_TABLE_WRITE 16'hFFFC
`define TXE_VAL_TABLE_WRITE 16'h000C
`define TXE_MASK_TEST_SKIP 16'hFE00
`define TXE_VAL_TEST_SKIP 16'h6600
`define TXE_MASK_XOR_LITERAL 16'hFF00
`define TXE_VAL_XOR_LITERAL 16'h0A00
`define TXE_MASK_XOR_FILE 16'hFC00
`define TXE_VAL_XOR_FILE 16'h1800
`define TXE_BIT_ACCESS 8
`define TXE_BIT_DEST 9

// pointer handling codes
`define TXE_PTR_KEEP 2'h0
`define TXE_PTR_POST_INC 2'h1
`define TXE_PTR_POST_DEC 2'h2
`define TXE_PTR_PRE_INC 2'h3

// addressing
`define TXE_INDEXED_MAX 8'h5F
`define TXE_ACCESS_SPLIT 8'h60
`define TXE_ACCESS_LOW_BANK 4'h0
`define TXE_ACCESS_HIGH_BANK 4'hF

// cycle counts and the instruction-cycle divider
`define TXE_Q_LAST 2'h3
`define TXE_CYC_ONE 2'h1
`define TXE_CYC_TWO 2'h2
`define TXE_CYC_THREE 2'h3

`endif

/* File: src/txe_pkg.sv */
// types for the table write, test-skip and xor execution block
package txe_pkg;

    typedef enum logic [1:0] {
        TXE_IDLE = 2'b01,
        TXE_RUN = 2'b10
    } txe_state_t;

    typedef enum logic [2:0] {
        TXE_OP_NONE = 3'h0,
        TXE_OP_TABLE_WRITE = 3'h1,
        TXE_OP_TEST_SKIP = 3'h2,
        TXE_OP_XOR_LITERAL = 3'h3,
        TXE_OP_XOR_FILE = 3'h4
    } txe_op_t;

endpackage

/* File: src/txe_decode.sv */
// opcode decode and effective file address for the execution block
`timescale 1ns/10ps
`include "txe_consts.svh"

module txe_decode (
    // instruction and addressing state
    input wire logic [15:0] instr,
    input wire logic ext_en,
    input wire logic [3:0] bank_select_register,
    input wire logic [11:0] index_base,
    // decoded fields
    output txe_pkg::txe_op_t op,
    output logic [1:0] ptr_mode,
    output logic dest_file,
    output logic [7:0] literal,
    output logic [11:0] eff_addr
);

    function automatic logic op_match(input logic [15:0] i,
                                      input logic [15:0] m,
                                      input logic [15:0] v);
        op_match = ((i & m) == v);
    endfunction

    logic access_bank;
    logic [7:0] f_addr;

    assign ptr_mode = instr[1:0];
    assign literal = instr[7:0];
    assign f_addr = instr[7:0];
    assign dest_file = instr[`TXE_BIT_DEST];
    assign access_bank = ~instr[`TXE_BIT_ACCESS];

    always_comb begin
        if (op_match(instr, `TXE_MASK_TABLE_WRITE, `TXE_VAL_TABLE_WRITE)) begin
            op = txe_pkg::TXE_OP_TABLE_WRITE;
        end else if (op_match(instr, `TXE_MASK_TEST_SKIP,
                              `TXE_VAL_TEST_SKIP)) begin
            op = txe_pkg::TXE_OP_TEST_SKIP;
        end else if (op_match(instr, `TXE_MASK_XOR_LITERAL,
                              `TXE_VAL_XOR_LITERAL)) begin
            op = txe_pkg::TXE_OP_XOR_LITERAL;
        end else if (op_match(instr, `TXE_MASK_XOR_FILE,
                              `TXE_VAL_XOR_FILE)) begin
            op = txe_pkg::TXE_OP_XOR_FILE;
        end else begin
            op = txe_pkg::TXE_OP_NONE;
        end
    end

    // indexed offset only with the extended set on, else plain banks
    always_comb begin
        if (!access_bank) begin
            eff_addr = {bank_select_register, f_addr};
        end else if (ext_en && (f_addr <= `TXE_INDEXED_MAX)) begin
            eff_addr = index_base + {4'h0, f_addr};
        end else if (f_addr < `TXE_ACCESS_SPLIT) begin
            eff_addr = {`TXE_ACCESS_LOW_BANK, f_addr};
        end else begin
            eff_addr = {`TXE_ACCESS_HIGH_BANK, f_addr};
        end
    end

endmodule // txe_decode

/* File: src/txe_holding.sv */
// eight program-memory holding registers fed by table writes
`timescale 1ns/10ps
`include "txe_consts.svh"

module txe_holding #(
    parameter int HOLD_COUNT = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write from the execution logic
    input wire logic wr_en,
    input wire logic [$clog2(HOLD_COUNT)-1:0] wr_index,
    input wire logic [7:0] wr_data,
    input wire logic wr_byte_high,
    // readback
    input wire logic [$clog2(HOLD_COUNT)-1:0] rd_index,
    output logic [7:0] rd_data,
    // to the flash programming side
    output logic hold_we,
    output logic [$clog2(HOLD_COUNT)-1:0] hold_index,
    output logic [7:0] hold_data,
    output logic hold_byte_high
);

    logic [7:0] hold [HOLD_COUNT];

    genvar gi;
    generate
        for (gi = 0; gi < HOLD_COUNT; gi++) begin : g_hold
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    hold[gi] <= 8'h00;
                end else if (wr_en && (wr_index == gi)) begin
                    hold[gi] <= wr_data;
                end
            end
        end
    endgenerate

    assign rd_data = hold[rd_index];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_we <= 1'b0;
            hold_index <= '0;
            hold_data <= 8'h00;
            hold_byte_high <= 1'b0;
        end else begin
            hold_we <= wr_en;
            if (wr_en) begin
                hold_index <= wr_index;
                hold_data <= wr_data;
                hold_byte_high <= wr_byte_high;
            end
        end
    end

endmodule // txe_holding

/* File: sim/txe_assertions.sv */
// port assertions for the table write, test-skip and xor block
`timescale 1ns/10ps
`include "txe_consts.svh"
module txe_assertions #(
    parameter int HOLD_COUNT = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TXE_PADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // flash programming side
    input wire logic hold_we,
    input wire logic [$clog2(HOLD_COUNT)-1:0] hold_index,
    input wire logic hold_byte_high,
    input wire logic [20:0] table_pointer
);
    logic [2:0] idx_gap;
    assign idx_gap = table_pointer[2:0] - 3'(hold_index);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_pulse;
        hold_we ##1 !hold_we;
    endsequence
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_access: assert property (pslverr |-> s_access)
        else $error("pslverr outside access");
    a_unaligned_err: assert property (s_access and paddr[1:0] != 2'h0
        |-> pslverr) else $error("unaligned not refused");
    a_hold_single: assert property ($rose(hold_we) |-> s_pulse)
        else $error("hold write not one cycle");
    a_byte_sel: assert property (hold_we |->
        hold_byte_high == hold_index[0]) else $error("byte select");
    a_hold_index: assert property (hold_we |->
        idx_gap inside {3'h0, 3'h1, 3'h7}) else $error("hold index");
    // a pointer change not made by software must be one step
    a_ptr_step: assert property ($changed(table_pointer) &&
        !$past(psel && penable && pwrite) |-> (table_pointer -
        $past(table_pointer)) inside {21'h1, 21'h1F_FFFF})
        else $error("pointer step");
    a_ptr_hold: assert property ($changed(table_pointer) &&
        !$past(psel && penable && pwrite) |-> ##[0:2] hold_we)
        else $error("pointer moved without hold write");
    a_rdata_hold: assert property ($changed(prdata) |->
        $past(psel && !penable)) else $error("prdata moved");
endmodule // txe_assertions

/* File: sim/txe_flash_model.sv */
// behavioural holding registers on the flash programming side
`timescale 1ns/10ps
module txe_flash_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // holding register writes
    input wire logic hold_we,
    input wire logic [2:0] hold_index,
    input wire logic [7:0] hold_data,
    input wire logic hold_byte_high
);
    logic [7:0] mem [8];
    logic hi [8];
    // no reset: an unwritten slot stays unknown and never matches
    always_ff @(posedge pclk) begin
        if (presetn && hold_we) begin
            mem[hold_index] <= hold_data;
            hi[hold_index] <= hold_byte_high;
        end
    end
endmodule // txe_flash_model

/* File: sim/table_write_test_xor_exec_tb_top.sv */
// testbench for the table write, test-skip and xor block
`timescale 1ns/10ps
`include "txe_consts.svh"
module table_write_test_xor_exec_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic hold_we, hold_byte_high;
    logic [7:0] paddr, hold_data;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] hold_index;
    logic [20:0] table_pointer, p, e, np;
    logic [20:0] sp [4] = '{21'h00_A356, 21'h1F_FFFF, 21'h0, 21'h01_389A};
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    txe_top i_txe_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hold_we(hold_we), .hold_index(hold_index),
        .hold_data(hold_data), .hold_byte_high(hold_byte_high),
        .table_pointer(table_pointer));
    txe_flash_model i_txe_flash_model (.pclk(pclk), .presetn(presetn),
        .hold_we(hold_we), .hold_index(hold_index),
        .hold_data(hold_data), .hold_byte_high(hold_byte_high));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // a hang ends the run as a failure
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    task close_out;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        checks++;
        if (g !== ex) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, g);
        end
    endtask
    // one apb transfer; answer taken at the edge that sees pready high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("write refused", 32'h0, {31'h0, er});
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, x, rd);
    endtask
    // poll busy; a poll limit that runs out is a mismatch
    task idle;
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, `TXE_OFF_STATUS, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        chk("busy", 32'h0, {31'h0, rd[0]});
    endtask
    task run(input logic [15:0] ins);
        wr(`TXE_OFF_INSTR, {16'h0, ins});
        idle();
    endtask
    task fset(input logic [11:0] a, input logic [7:0] d);
        wr(`TXE_OFF_FILE_INDEX, {20'h0, a});
        wr(`TXE_OFF_FILE_DATA, {24'h0, d});
    endtask
    task stat(input logic [1:0] c, input logic n, z, s);
        rchk("status", `TXE_OFF_STATUS, {22'h0, c, 4'h0, n, z, s, 1'b0});
    endtask
    task xl(input logic [7:0] k, ew, input logic n, z);
        run({8'h0A, k});
        rchk("w", `TXE_OFF_WREG, {24'h0, ew});
        stat(2'h1, n, z, 1'b0);
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        stat(2'h0, 1'b0, 1'b0, 1'b0);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1'b0, 8'h02, 32'h0);
        chk("unaligned", 32'h1, {31'h0, er});
        $display("test reset done");
        wr(`TXE_OFF_WREG, 32'h0000_00B5);
        xl(8'hAF, 8'h1A, 1'b0, 1'b0);
        xl(8'h1A, 8'h00, 1'b0, 1'b1);
        xl(8'h80, 8'h80, 1'b1, 1'b0);
        $display("test xor literal done");
        for (int m = 0; m < 4; m++) begin
            p = sp[m];
            e = (m == 3) ? p + 21'h1 : p;
            np = (m == 1 || m == 3) ? p + 21'h1 : (m == 2) ? p - 21'h1 : p;
            wr(`TXE_OFF_LATCH, 32'h50 + m);
            wr(`TXE_OFF_TABLE_PTR, {11'h0, p});
            run(16'h000C | 16'(m));
            stat(2'h2, 1'b1, 1'b0, 1'b0);
            rchk("pointer", `TXE_OFF_TABLE_PTR, {11'h0, np});
            chk("ptr port", {11'h0, np}, {11'h0, table_pointer});
            rchk("holding", 8'(`TXE_OFF_HOLD_FIRST + 4 * e[2:0]),
                32'h50 + m);
            chk("model", 32'h50 + m, {24'h0,
                i_txe_flash_model.mem[e[2:0]]});
            chk("byte", {31'h0, e[0]},
                {31'h0, i_txe_flash_model.hi[e[2:0]]});
        end
        $display("test table write done");
        fset(12'h020, 8'hAF);
        wr(`TXE_OFF_WREG, 32'h0000_00B5);
        run(16'h1A20);
        wr(`TXE_OFF_FILE_INDEX, 32'h0000_0020);
        rchk("file", `TXE_OFF_FILE_DATA, 32'h0000_001A);
        rchk("w", `TXE_OFF_WREG, 32'h0000_00B5);
        wr(`TXE_OFF_BANK, 32'h0000_0001);
        fset(12'h120, 8'h0F);
        run(16'h1920);
        rchk("w", `TXE_OFF_WREG, 32'h0000_00BA);
        stat(2'h1, 1'b1, 1'b0, 1'b0);
        $display("test xor file done");
        fset(12'h010, 8'h05);
        fset(12'h110, 8'h00);
        wr(`TXE_OFF_INDEX_BASE, 32'h0000_0100);
        run(16'h6610);
        stat(2'h1, 1'b1, 1'b0, 1'b0);
        wr(`TXE_OFF_CTRL, 32'h0000_0001);
        run(16'h6610);
        stat(2'h2, 1'b1, 1'b0, 1'b1);
        wr(`TXE_OFF_CTRL, 32'h0000_0003);
        rchk("ctrl", `TXE_OFF_CTRL, 32'h0000_0003);
        run(16'h6610);
        stat(2'h3, 1'b1, 1'b0, 1'b1);
        $display("test skip done");
        // a w register write while busy must be refused
        apb(1'b1, `TXE_OFF_INSTR, 32'h0000_000C);
        apb(1'b1, `TXE_OFF_WREG, 32'h0000_0011);
        chk("busy refusal", 32'h1, {31'h0, er});
        idle();
        run(16'h0A00);
        rchk("w", `TXE_OFF_WREG, 32'h0000_00BA);
        // unknown opcode: one cycle, illegal set, flags kept
        run(16'hFFFF);
        rchk("status", `TXE_OFF_STATUS, 32'h0000_0118);
        $display("test busy done");
        close_out();
    end
endmodule // table_write_test_xor_exec_tb_top
bind txe_top txe_assertions #(.HOLD_COUNT(HOLD_COUNT)) i_txe_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hold_we(hold_we), .hold_index(hold_index),
    .hold_byte_high(hold_byte_high), .table_pointer(table_pointer));
